// *** design/src_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the reset controller
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH

`define SRC_CAUSE_ADDR 8'h00
`define SRC_BOR_CTRL_ADDR 8'h04
`define SRC_SOFT_RST_ADDR 8'h08
`define SRC_SYS_REQ_ADDR 8'h0C
`define SRC_WDT_LOAD_ADDR 8'h10
`define SRC_WDT_CTRL_ADDR 8'h14
`define SRC_LDO_CTRL_ADDR 8'h18
`define SRC_STATUS_ADDR 8'h1C

`define SRC_CAUSE_EXT 0
`define SRC_CAUSE_POR 1
`define SRC_CAUSE_BOR 2
`define SRC_CAUSE_SW 3
`define SRC_CAUSE_WDT 4
`define SRC_CAUSE_LDO 5

`define SRC_BOR_SEL_BIT 0
`define SRC_BOR_WAIT_BIT 1
`define SRC_BOR_DLY_LSB 2
`define SRC_BOR_DLY_W 8

`define SRC_WDT_EN_BIT 0
`define SRC_WDT_RST_EN_BIT 1
`define SRC_WDT_INT_CLR_BIT 2

`define SRC_BOR_CTRL_RESET 32'h0000_0000
`define SRC_WDT_LOAD_RESET 32'hFFFF_FFFF

`define SRC_CLK_HZ 10000000
`define SRC_SETTLE_MS 15
`define SRC_SETTLE_CYC ((`SRC_SETTLE_MS * `SRC_CLK_HZ + 999) / 1000)
`define SRC_BOR_HOLD_US 500
`define SRC_BOR_HOLD_CYC ((`SRC_BOR_HOLD_US * `SRC_CLK_HZ) / 1000000)
`define SRC_INT_RST_CYC 16

`endif

// *** design/src_pkg.sv ***
// Types of the reset controller
package src_pkg;
  typedef enum logic [2:0] {
    SRC_WAIT_INPUTS,
    SRC_SETTLE,
    SRC_LOAD_SP,
    SRC_LOAD_PC,
    SRC_RUN,
    SRC_INT_HOLD
  } src_state_e;
  typedef logic [31:0] src_word_t;
endpackage

// *** design/src_reset_ctrl.sv ***
// Reset controller: source merge, sequencing, cause flags, brown-out filter, soft resets
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "src_regs.svh"

module src_reset_ctrl #(
  parameter int NUM_PERIPH = 32,
  parameter int DOMAINS = 2,
  parameter int SETTLE_CYC = `SRC_SETTLE_CYC,
  parameter int BOR_HOLD_CYC = `SRC_BOR_HOLD_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Pins and analog detectors
  input wire logic ext_reset_n_i,
  input wire logic por_i,
  input wire logic brownout_i,
  input wire logic ldo_unreg_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire src_pkg::src_word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output src_pkg::src_word_t rdata_o,
  // Core handshake
  output logic core_reset_n_o,
  output logic debug_reset_n_o,
  output logic load_sp_o,
  output logic load_pc_o,
  output logic core_run_o,
  output logic brownout_irq_o,
  output logic watchdog_irq_o,
  // Peripheral resets, one per clock domain of each unit
  output logic [NUM_PERIPH*DOMAINS-1:0] periph_reset_n_o
);
  import src_pkg::*;

  initial begin
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32 || DOMAINS < 1 || SETTLE_CYC < 1 ||
        BOR_HOLD_CYC < 1) begin
      $error("src_reset_ctrl: unsupported parameters");
    end
  end

  // Pin and detector synchronisers
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Idle pin and asserted power-on, so no false pin reset follows release
      sync1 <= 4'h2;
      sync2 <= 4'h2;
    end else if (clk_en_i) begin
      sync1 <= {ldo_unreg_i, brownout_i, por_i, ~ext_reset_n_i};
      sync2 <= sync1;
    end
  end
  logic ext_req;
  logic por_raw;
  logic bor_raw;
  logic ldo_raw;
  assign ext_req = sync2[0];
  assign por_raw = sync2[1];
  assign bor_raw = sync2[2];
  assign ldo_raw = sync2[3];

  // Power-on seen only until the first power-up completes
  logic powered_up;
  logic por_req;
  assign por_req = por_raw && !powered_up;

  src_state_e state;
  logic [31:0] count;
  logic int_req;
  logic ext_pending;
  logic por_pending;

  // Registers
  logic [5:0] cause;
  logic [31:0] bor_ctrl;
  logic [NUM_PERIPH-1:0] soft_rst;
  logic [31:0] wdt_load;
  logic wdt_en;
  logic wdt_rst_en;
  logic ldo_rst_en;
  logic sys_req;
  logic wdt_int_clr;
  logic wr_cause;
  assign wr_cause = wr_i && addr_i == `SRC_CAUSE_ADDR;
  assign sys_req = wr_i && addr_i == `SRC_SYS_REQ_ADDR && wdata_i[0];
  assign wdt_int_clr = wr_i && addr_i == `SRC_WDT_CTRL_ADDR && wdata_i[`SRC_WDT_INT_CLR_BIT];

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bor_ctrl <= `SRC_BOR_CTRL_RESET;
      soft_rst <= '0;
      wdt_load <= `SRC_WDT_LOAD_RESET;
      wdt_en <= 1'b0;
      wdt_rst_en <= 1'b0;
      ldo_rst_en <= 1'b0;
    end else if (clk_en_i && wr_i) begin
      if (addr_i == `SRC_BOR_CTRL_ADDR) begin
        bor_ctrl <= {22'h0, wdata_i[`SRC_BOR_DLY_LSB+`SRC_BOR_DLY_W-1:0]};
      end else if (addr_i == `SRC_SOFT_RST_ADDR) begin
        soft_rst <= wdata_i[NUM_PERIPH-1:0];
      end else if (addr_i == `SRC_WDT_LOAD_ADDR) begin
        wdt_load <= wdata_i;
      end else if (addr_i == `SRC_WDT_CTRL_ADDR) begin
        wdt_en <= wdata_i[`SRC_WDT_EN_BIT];
        wdt_rst_en <= wdata_i[`SRC_WDT_RST_EN_BIT];
      end else if (addr_i == `SRC_LDO_CTRL_ADDR) begin
        ldo_rst_en <= wdata_i[0];
      end
    end
  end

  // Brown-out filter: detect, optional resample, 500 us hold-off
  logic bor_cond;
  logic [31:0] bor_hold;
  logic [7:0] bor_dly;
  logic bor_waiting;
  logic bor_req;
  logic bor_irq_set;
  logic bor_sel;
  logic bor_wait;
  assign bor_sel = bor_ctrl[`SRC_BOR_SEL_BIT];
  assign bor_wait = bor_ctrl[`SRC_BOR_WAIT_BIT];
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bor_cond <= 1'b0;
      bor_hold <= '0;
      bor_dly <= '0;
      bor_waiting <= 1'b0;
      bor_req <= 1'b0;
      bor_irq_set <= 1'b0;
    end else if (clk_en_i) begin
      bor_req <= 1'b0;
      bor_irq_set <= 1'b0;
      // Resample runs apart from the hold-off, so a delay longer than it still ends
      if (bor_waiting) begin
        if (bor_dly == 8'h00) begin
          bor_waiting <= 1'b0;
          bor_irq_set <= bor_raw;
        end else begin
          bor_dly <= bor_dly - 8'h01;
        end
      end
      if (bor_cond) begin
        if (bor_hold == 32'(BOR_HOLD_CYC - 1)) begin
          bor_cond <= 1'b0;
        end
        bor_hold <= bor_hold + 32'h1;
      end else if (bor_raw && !bor_waiting) begin
        bor_cond <= 1'b1;
        bor_hold <= '0;
        if (bor_sel) begin
          bor_req <= 1'b1;
        end else if (bor_wait) begin
          bor_waiting <= 1'b1;
          bor_dly <= bor_ctrl[`SRC_BOR_DLY_LSB+:`SRC_BOR_DLY_W];
        end else begin
          bor_irq_set <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brownout_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      if (bor_irq_set) begin
        brownout_irq_o <= 1'b1;
      end else if (wr_i && addr_i == `SRC_BOR_CTRL_ADDR) begin
        brownout_irq_o <= 1'b0;
      end
    end
  end

  // Watchdog: first timeout interrupts, second uncleared one resets
  logic [31:0] wdt_count;
  logic wdt_req;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_count <= `SRC_WDT_LOAD_RESET;
      watchdog_irq_o <= 1'b0;
      wdt_req <= 1'b0;
    end else if (clk_en_i) begin
      wdt_req <= 1'b0;
      if (!wdt_en || !core_run_o) begin
        wdt_count <= wdt_load;
        if (wdt_int_clr) begin
          watchdog_irq_o <= 1'b0;
        end
      end else if (wdt_count == 32'h0) begin
        wdt_count <= wdt_load;
        watchdog_irq_o <= 1'b1;
        wdt_req <= watchdog_irq_o && wdt_rst_en && !wdt_int_clr;
      end else begin
        wdt_count <= wdt_count - 32'h1;
        if (wdt_int_clr) begin
          watchdog_irq_o <= 1'b0;
        end
      end
    end
  end

  logic ldo_req;
  assign ldo_req = ldo_raw && ldo_rst_en && core_run_o;

  // Merged reset requests; bits 5:2 form the internal request
  logic [5:0] req;
  assign req = {ldo_req, wdt_req, sys_req && core_run_o, bor_req, por_req, ext_req};
  assign int_req = |req[5:2];

  // Sequencer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= SRC_WAIT_INPUTS;
      count <= '0;
      powered_up <= 1'b0;
      ext_pending <= 1'b0;
      por_pending <= 1'b1;
    end else if (clk_en_i) begin
      case (state)
        SRC_WAIT_INPUTS: begin
          count <= '0;
          if (!ext_req && !por_req) begin
            state <= SRC_SETTLE;
          end
        end
        SRC_SETTLE: begin
          if (ext_req || por_req) begin
            state <= SRC_WAIT_INPUTS;
          end else if (count == 32'(SETTLE_CYC - 1)) begin
            state <= SRC_LOAD_SP;
            powered_up <= 1'b1;
            ext_pending <= 1'b0;
            por_pending <= 1'b0;
          end else begin
            count <= count + 32'h1;
          end
        end
        SRC_INT_HOLD: begin
          if (ext_req) begin
            state <= SRC_WAIT_INPUTS;
          end else if (count == 32'(`SRC_INT_RST_CYC - 1)) begin
            state <= SRC_LOAD_SP;
          end else begin
            count <= count + 32'h1;
          end
        end
        SRC_LOAD_SP: begin
          state <= SRC_LOAD_PC;
        end
        SRC_LOAD_PC: begin
          state <= SRC_RUN;
        end
        default: begin
          if (ext_req) begin
            state <= SRC_WAIT_INPUTS;
            ext_pending <= 1'b1;
          end else if (int_req) begin
            state <= SRC_INT_HOLD;
            count <= '0;
          end
        end
      endcase
      if (ext_req) begin
        ext_pending <= 1'b1;
      end
    end
  end

  // Cause flags: hardware set wins over software clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cause <= '0;
    end else if (clk_en_i) begin
      if (ext_req) begin
        cause <= 6'h01;
      end else begin
        cause <= ((wr_cause ? (cause & ~wdata_i[5:0]) : cause) | req) & ~6'h01;
        if (cause[`SRC_CAUSE_EXT] && !(wr_cause && wdata_i[0])) begin
          cause[`SRC_CAUSE_EXT] <= 1'b1;
        end
      end
    end
  end

  // Outputs
  logic in_reset;
  assign in_reset = state == SRC_WAIT_INPUTS || state == SRC_SETTLE || state == SRC_INT_HOLD;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_reset_n_o <= 1'b0;
      debug_reset_n_o <= 1'b0;
      load_sp_o <= 1'b0;
      load_pc_o <= 1'b0;
      core_run_o <= 1'b0;
    end else if (clk_en_i) begin
      core_reset_n_o <= !(in_reset || int_req || ext_req);
      debug_reset_n_o <= !(por_req || (por_pending && !powered_up));
      load_sp_o <= state == SRC_LOAD_SP;
      load_pc_o <= state == SRC_LOAD_PC;
      core_run_o <= state == SRC_RUN && !ext_req && !int_req;
    end
  end

  // Per-unit soft reset fanned to every clock domain of the unit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH * DOMAINS; gi++) begin : g_dom
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          periph_reset_n_o[gi] <= 1'b0;
        end else if (clk_en_i) begin
          periph_reset_n_o[gi] <= !(soft_rst[gi / DOMAINS] || !core_reset_n_o);
        end
      end
    end
  endgenerate

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (clk_en_i) begin
      rdata_o <= '0;
      if (rd_i) begin
        if (addr_i == `SRC_CAUSE_ADDR) begin
          rdata_o <= {26'h0, cause};
        end else if (addr_i == `SRC_BOR_CTRL_ADDR) begin
          rdata_o <= bor_ctrl;
        end else if (addr_i == `SRC_SOFT_RST_ADDR) begin
          rdata_o <= 32'(soft_rst);
        end else if (addr_i == `SRC_WDT_LOAD_ADDR) begin
          rdata_o <= wdt_load;
        end else if (addr_i == `SRC_WDT_CTRL_ADDR) begin
          rdata_o <= {29'h0, watchdog_irq_o, wdt_rst_en, wdt_en};
        end else if (addr_i == `SRC_LDO_CTRL_ADDR) begin
          rdata_o <= {31'h0, ldo_rst_en};
        end else if (addr_i == `SRC_STATUS_ADDR) begin
          rdata_o <= {27'h0, brownout_irq_o, bor_cond, state};
        end
      end
    end
  end

  logic unused;
  assign unused = ext_pending;
endmodule

// *** tb/src_reset_ctrl_assertions.sv ***
// Concurrent checks on the reset controller ports
`timescale 1ns/1ps
module src_reset_ctrl_assertions #(
  parameter int NUM_PERIPH = 32,
  parameter int DOMAINS = 2,
  parameter int SETTLE_CYC = 20
) (
  // Clock, reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Inputs watched
  input wire logic ext_reset_n_i,
  input wire logic por_i,
  input wire logic [7:0] addr_i,
  input wire src_pkg::src_word_t wdata_i,
  input wire logic wr_i,
  // Outputs watched
  input wire logic core_reset_n_o,
  input wire logic debug_reset_n_o,
  input wire logic load_sp_o,
  input wire logic load_pc_o,
  input wire logic core_run_o,
  input wire logic [NUM_PERIPH*DOMAINS-1:0] periph_reset_n_o
);
  import src_pkg::*;
  int settle_cnt;
  logic pin_seen;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Quiet time since pin and power-on; internal resets skip the settle count
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_cnt <= 0;
      pin_seen <= 1'b1;
    end else begin
      if (!ext_reset_n_i || por_i) begin
        settle_cnt <= 0;
      end else if (!core_reset_n_o) begin
        settle_cnt <= settle_cnt + 1;
      end
      pin_seen <= (!ext_reset_n_i || por_i) ? 1'b1 : (core_reset_n_o ? 1'b0 : pin_seen);
    end
  end
  sequence boot_s;
    load_sp_o ##1 load_pc_o ##1 core_run_o;
  endsequence
  boot_order_a: assert property (load_sp_o |-> boot_s)
    else $error("boot steps out of order");
  run_after_pc_a: assert property ($rose(core_run_o) |-> $past(load_pc_o))
    else $error("run without program counter load");
  run_reset_a: assert property (core_run_o |-> core_reset_n_o)
    else $error("core runs while held in reset");
  pin_reset_a: assert property ($fell(ext_reset_n_i) |-> ##[1:4]
    (!core_reset_n_o && periph_reset_n_o == '0))
    else $error("pin did not reset core and peripherals");
  debug_hold_a: assert property (debug_reset_n_o |=> debug_reset_n_o)
    else $error("debug reset reasserted");
  settle_time_a: assert property ($rose(core_reset_n_o) && pin_seen |->
    settle_cnt >= SETTLE_CYC && settle_cnt <= 2 * SETTLE_CYC + 8)
    else $error("settle time out of range");
  sys_req_a: assert property (wr_i && addr_i == 8'h0C && wdata_i[0] && core_run_o
    |-> ##[1:3] !core_reset_n_o)
    else $error("system request gave no reset");
  soft_reset_a: assert property (wr_i && addr_i == 8'h08 && wdata_i[0]
    |-> ##[1:3] periph_reset_n_o[DOMAINS-1:0] == '0)
    else $error("unit domains not all reset");
endmodule

// *** tb/src_analog_model.sv ***
// Pin and analog detector model facing the reset controller
`timescale 1ns/1ps
module src_analog_model (
  // Clock
  input wire logic ref_clk_i,
  // Requests from the bench
  input wire logic pin_req_i,
  input wire logic por_req_i,
  input wire logic bor_req_i,
  input wire logic ldo_req_i,
  // Pin and detector lines
  output logic ext_reset_n_o = 1'b1,
  output logic por_o = 1'b1,
  output logic brownout_o = 1'b0,
  output logic ldo_unreg_o = 1'b0
);
  int up_cnt = 0;
  // Pin has a pull-up, so a released pin reads high
  always @(posedge ref_clk_i) begin
    up_cnt <= (up_cnt < 40) ? up_cnt + 1 : up_cnt;
    ext_reset_n_o <= !pin_req_i;
    // Late power-on pulse only when a scenario asks for it
    por_o <= (up_cnt < 30) || por_req_i;
    brownout_o <= bor_req_i;
    ldo_unreg_o <= ldo_req_i;
  end
endmodule

// *** tb/src_reset_ctrl_tb.sv ***
// Self-checking bench of the reset controller
`timescale 1ns/1ps
module src_reset_ctrl_tb;
  import src_pkg::*;
  localparam src_word_t M = 32'hFFFF_FFFF;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pin_req = 1'b0, por_req = 1'b0, bor_req = 1'b0, ldo_req = 1'b0;
  logic ext_reset_n, por, brownout, ldo_unreg;
  logic [7:0] addr_i = 8'h00;
  src_word_t wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0;
  src_word_t rdata_o;
  logic core_reset_n_o, debug_reset_n_o, load_sp_o, load_pc_o, core_run_o;
  logic brownout_irq_o, watchdog_irq_o;
  logic [63:0] periph_reset_n_o;
  int errors = 0;
  int tests_run = 0;
  int n;
  always #50 ref_clk_i = !ref_clk_i;
  src_analog_model model (.ref_clk_i, .pin_req_i(pin_req), .por_req_i(por_req),
    .bor_req_i(bor_req), .ldo_req_i(ldo_req), .ext_reset_n_o(ext_reset_n),
    .por_o(por), .brownout_o(brownout), .ldo_unreg_o(ldo_unreg));
  src_reset_ctrl #(.SETTLE_CYC(20), .BOR_HOLD_CYC(10)) uut (.ref_clk_i, .reset_n_i,
    .clk_en_i(1'b1), .ext_reset_n_i(ext_reset_n), .por_i(por), .brownout_i(brownout),
    .ldo_unreg_i(ldo_unreg), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .core_reset_n_o, .debug_reset_n_o, .load_sp_o, .load_pc_o, .core_run_o,
    .brownout_irq_o, .watchdog_irq_o, .periph_reset_n_o);
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input src_word_t d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input src_word_t m, input src_word_t e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    check(rdata_o & m, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  // 0: running, 1: watchdog interrupt, 2: core held in reset
  function automatic logic pick(input int s);
    return s == 0 ? core_run_o : (s == 1 ? watchdog_irq_o : !core_reset_n_o);
  endfunction
  task automatic wait_for(input int s);
    n = 0;
    while (pick(s) !== 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 400) begin
      errors++;
      $display("mismatch at %0t: wait expired", $time);
      print_verdict;
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    cyc(4);
    check(debug_reset_n_o, 1'b0);
    check(core_reset_n_o, 1'b0);
    wait_for(0);
    check(debug_reset_n_o, 1'b1);
    rd(8'h00, M, 32'h2);
    rd(8'h04, M, 32'h0);
    rd(8'h10, M, 32'hFFFF_FFFF);
    rd(8'h40, M, 32'h0);
    wr(8'h0C, 32'h1);
    wait_for(2);
    wait_for(0);
    rd(8'h00, M, 32'hA);
    @(posedge ref_clk_i) por_req <= 1'b1;
    cyc(10);
    check(core_run_o, 1'b1);
    @(posedge ref_clk_i) por_req <= 1'b0;
    // Brown-out with no select and no wait: interrupt only
    @(posedge ref_clk_i) bor_req <= 1'b1;
    cyc(4);
    rd(8'h1C, 32'h8, 32'h8);
    @(posedge ref_clk_i) bor_req <= 1'b0;
    cyc(2);
    check(brownout_irq_o, 1'b1);
    check(core_run_o, 1'b1);
    cyc(15);
    rd(8'h1C, 32'h8, 32'h0);
    wr(8'h04, 32'h52);
    cyc(2);
    check(brownout_irq_o, 1'b0);
    // Pulse shorter than the resample delay is filtered out
    @(posedge ref_clk_i) bor_req <= 1'b1;
    cyc(2);
    @(posedge ref_clk_i) bor_req <= 1'b0;
    cyc(40);
    check(brownout_irq_o, 1'b0);
    @(posedge ref_clk_i) bor_req <= 1'b1;
    cyc(40);
    check(brownout_irq_o, 1'b1);
    @(posedge ref_clk_i) bor_req <= 1'b0;
    wr(8'h04, 32'h1);
    @(posedge ref_clk_i) bor_req <= 1'b1;
    wait_for(2);
    @(posedge ref_clk_i) bor_req <= 1'b0;
    wait_for(0);
    rd(8'h00, M, 32'hE);
    @(posedge ref_clk_i) ldo_req <= 1'b1;
    cyc(10);
    check(core_run_o, 1'b1);
    @(posedge ref_clk_i) ldo_req <= 1'b0;
    cyc(4);
    wr(8'h18, 32'h1);
    @(posedge ref_clk_i) ldo_req <= 1'b1;
    wait_for(2);
    @(posedge ref_clk_i) ldo_req <= 1'b0;
    wait_for(0);
    rd(8'h00, M, 32'h2E);
    wr(8'h10, 32'd20);
    wr(8'h14, 32'h3);
    wait_for(1);
    check(core_run_o, 1'b1);
    wait_for(2);
    wait_for(0);
    wr(8'h14, 32'h4);
    rd(8'h00, M, 32'h3E);
    for (int u = 0; u < 32; u += 31) begin
      wr(8'h08, 32'h1 << u);
      cyc(2);
      check(periph_reset_n_o, ~(64'h3 << (2 * u)));
      wr(8'h08, 32'h0);
      cyc(2);
      check(periph_reset_n_o, {64{1'b1}});
    end
    @(posedge ref_clk_i) pin_req <= 1'b1;
    cyc(6);
    check(core_reset_n_o, 1'b0);
    check(debug_reset_n_o, 1'b1);
    @(posedge ref_clk_i) pin_req <= 1'b0;
    cyc(18);
    check(core_run_o, 1'b0);
    wait_for(0);
    rd(8'h00, M, 32'h1);
    print_verdict;
  end
endmodule
bind src_reset_ctrl src_reset_ctrl_assertions #(.NUM_PERIPH(NUM_PERIPH), .DOMAINS(DOMAINS),
  .SETTLE_CYC(SETTLE_CYC)) chk (.ref_clk_i, .reset_n_i, .ext_reset_n_i, .por_i,
  .addr_i, .wdata_i, .wr_i, .core_reset_n_o, .debug_reset_n_o, .load_sp_o,
  .load_pc_o, .core_run_o, .periph_reset_n_o);
